// file: src/lbte_ctrl.sv
// Loopback selection and transmit emphasis control of a quad bidirectional equalizer.
// Assumes a serial register interface decoder supplies single-cycle write and read strobes
// on clk, and that the control mode comes from logic on the same clock.
`timescale 1ns/1ps
module lbte_ctrl
	import lbte_pkg::*;
#(
	parameter int N_LANES = lbte_pkg::LANES
) (
	input  wire logic                                        clk,
	input  wire logic                                        reset,
	input  wire logic [lbte_pkg::ADDR_W-1:0]                 reg_addr,
	input  wire logic [lbte_pkg::DATA_W-1:0]                 reg_wdata,
	input  wire logic                                        reg_wr_en,
	input  wire logic                                        reg_rd_en,
	output logic      [lbte_pkg::DATA_W-1:0]                 reg_rdata,
	input  wire logic [1:0]                                  control_mode,
	input  wire logic                                        loopback_toggle_pin,
	input  wire logic [1:0]                                  emphasis_toggle_pins_a,
	input  wire logic [1:0]                                  emphasis_toggle_pins_b,
	output logic                                             cable_loop_en,
	output logic                                             board_loop_en,
	output logic                                             port_a_through_en,
	output logic                                             port_b_through_en,
	output logic                                             port_a_out_from_b,
	output logic                                             port_b_out_from_a,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0]          lane_out_enable,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0]          lane_rate_high,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0]          lane_direct_level,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0][2:0]     lane_emph_setting,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0][6:0]     lane_level1,
	output logic [lbte_pkg::PORTS-1:0][N_LANES-1:0][6:0]     lane_level0
);
	import lbte_pkg::*;

	typedef enum logic [1:0] {
		LBTE_SEL_NONE = 2'h0,
		LBTE_SEL_CFG  = 2'h1,
		LBTE_SEL_LV1  = 2'h2,
		LBTE_SEL_LV0  = 2'h3
	} lbte_sel_t;

	logic [7:0]             loopback_control_reg;
	logic [PORTS-1:0][7:0]  out_cfg_reg;
	logic [PORTS-1:0][7:0]  out_level1_reg;
	logic [PORTS-1:0][7:0]  out_level0_reg;
	logic [PORTS-1:0]       emph_written_reg;
	logic                   loop_pin_sync;
	logic [3:0]             emph_pins_sync;
	logic [PORTS-1:0][1:0]  emph_pins;
	logic                   cable_next;
	logic                   board_next;
	lbte_sel_t              acc_sel;
	logic                   acc_port;
	logic [7:0]             rdata_next;

	// Output port block of an address, and which register inside it
	function automatic lbte_sel_t out_reg_sel(input logic [7:0] addr);
		lbte_sel_t sel;
		sel = LBTE_SEL_NONE;
		for (int p = 0; p < PORTS; p++)
		begin
			if (addr == 8'(OUT_CFG_A_ADDR + 8'(p) * PORT_STRIDE))
				sel = LBTE_SEL_CFG;
			if (addr == 8'(OUT_LEVEL1_A_ADDR + 8'(p) * PORT_STRIDE))
				sel = LBTE_SEL_LV1;
			if (addr == 8'(OUT_LEVEL0_A_ADDR + 8'(p) * PORT_STRIDE))
				sel = LBTE_SEL_LV0;
		end
		return sel;
	endfunction

	function automatic logic out_reg_port(input logic [7:0] addr);
		return (addr & PORT_STRIDE) != 8'h00;
	endfunction

	// Pins reach only the even map settings, so their low bit is forced to zero
	function automatic logic [2:0] emph_pick(input logic written, input logic [7:0] cfg,
		input logic [1:0] pins);
		if (written)
			return cfg[EMPH_FIELD_LSB +: EMPH_FIELD_W];
		else
			return {pins, 1'b0};
	endfunction

	assign acc_sel  = out_reg_sel(reg_addr);
	assign acc_port = out_reg_port(reg_addr);

	// Pins are moved into clk before any selection logic sees them
	lbte_sync #(.WIDTH(1)) u_loop_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in (loopback_toggle_pin),
		.sync_out (loop_pin_sync)
	);

	lbte_sync #(.WIDTH(4)) u_emph_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({emphasis_toggle_pins_b, emphasis_toggle_pins_a}),
		.sync_out (emph_pins_sync)
	);

	assign emph_pins[0] = emph_pins_sync[1:0];
	assign emph_pins[1] = emph_pins_sync[3:2];

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			loopback_control_reg <= LOOPBACK_CONTROL_RESET;
		else if (reg_wr_en && reg_addr == LOOPBACK_CONTROL_ADDR)
			loopback_control_reg <= reg_wdata & LOOPBACK_CONTROL_MASK;
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				out_cfg_reg[p]    <= OUT_CFG_RESET;
				out_level1_reg[p] <= OUT_LEVEL1_RESET;
				out_level0_reg[p] <= OUT_LEVEL0_RESET;
			end
		end
		else if (reg_wr_en)
		begin
			// Unsupported level codes are stored as written; the analog side defines them
			unique case (acc_sel)
				LBTE_SEL_CFG: out_cfg_reg[acc_port]    <= reg_wdata & OUT_CFG_MASK;
				LBTE_SEL_LV1: out_level1_reg[acc_port] <= reg_wdata & OUT_LEVEL1_MASK;
				LBTE_SEL_LV0: out_level0_reg[acc_port] <= reg_wdata & OUT_LEVEL0_MASK;
				LBTE_SEL_NONE: ;
			endcase
		end
	end

	// Once software writes a port's configuration its field beats the pins until reset
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			emph_written_reg <= '0;
		else if (reg_wr_en && acc_sel == LBTE_SEL_CFG)
			emph_written_reg[acc_port] <= 1'b1;
	end

	// Loopback decode
	always_comb
	begin
		if (control_mode[SERIAL_MODE_BIT])
		begin
			cable_next = loopback_control_reg[CABLE_SIDE_LOOP_BIT];
			board_next = loopback_control_reg[BOARD_SIDE_LOOP_BIT];
		end
		else
		begin
			cable_next = 1'b0;
			board_next = loop_pin_sync;
		end
	end

	// Loop enables are registered so the datapath muxes see one settled select per cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cable_loop_en <= 1'b0;
			board_loop_en <= 1'b0;
		end
		else
		begin
			cable_loop_en <= cable_next;
			board_loop_en <= board_next;
		end
	end

	// Source selects track the enables; in board loop Port B still feeds its own outputs
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			port_a_out_from_b <= 1'b0;
			port_b_out_from_a <= 1'b0;
		end
		else
		begin
			port_a_out_from_b <= board_next;
			port_b_out_from_a <= cable_next;
		end
	end

	// Full loopback takes both outputs, so through traffic stops on every lane
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			port_a_through_en <= 1'b1;
			port_b_through_en <= 1'b1;
		end
		else
		begin
			port_a_through_en <= !(cable_next && board_next);
			port_b_through_en <= !(cable_next && board_next);
		end
	end

	// Transmit settings, one port value fanned out to every lane
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lane_out_enable <= '0;
			lane_rate_high  <= '0;
		end
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				for (int l = 0; l < N_LANES; l++)
				begin
					lane_out_enable[p][l] <= out_cfg_reg[p][OUT_ENABLE_BIT];
					lane_rate_high[p][l]  <= out_cfg_reg[p][DATA_RATE_BIT];
				end
			end
		end
	end

	// Direct level values pass on even while the map is in use; the analog side picks
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lane_direct_level <= '0;
			lane_level1       <= '0;
			lane_level0       <= '0;
		end
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				for (int l = 0; l < N_LANES; l++)
				begin
					lane_direct_level[p][l] <= out_level1_reg[p][EMPH_SOURCE_BIT];
					lane_level1[p][l]       <= out_level1_reg[p][LEVEL_W-1:0];
					lane_level0[p][l]       <= out_level0_reg[p][LEVEL_W-1:0];
				end
			end
		end
	end

	// Emphasis setting per lane, register field once written, else the pins
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			lane_emph_setting <= '0;
		else
		begin
			for (int p = 0; p < PORTS; p++)
			begin
				for (int l = 0; l < N_LANES; l++)
				begin
					lane_emph_setting[p][l] <= emph_pick(emph_written_reg[p], out_cfg_reg[p],
						emph_pins[p]);
				end
			end
		end
	end

	// Read path; unmapped addresses read as zero
	always_comb
	begin
		rdata_next = READ_UNMAPPED;
		if (reg_addr == LOOPBACK_CONTROL_ADDR)
			rdata_next = loopback_control_reg;
		else
		begin
			unique case (acc_sel)
				LBTE_SEL_CFG:  rdata_next = out_cfg_reg[acc_port];
				LBTE_SEL_LV1:  rdata_next = out_level1_reg[acc_port];
				LBTE_SEL_LV0:  rdata_next = out_level0_reg[acc_port];
				LBTE_SEL_NONE: rdata_next = READ_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			reg_rdata <= READ_UNMAPPED;
		else if (reg_rd_en)
			reg_rdata <= rdata_next;
	end
endmodule // lbte_ctrl

// file: src/lbte_pkg.sv
// Package for the loopback and transmit emphasis control block.
// Assumes an 8-bit register space reached through the chip's serial register interface.
package lbte_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int PORTS  = 2;
	localparam int LANES  = 4;

	localparam logic [7:0] LOOPBACK_CONTROL_ADDR = 8'h02;
	localparam logic [7:0] OUT_CFG_A_ADDR        = 8'hC0;
	localparam logic [7:0] OUT_LEVEL1_A_ADDR     = 8'hC1;
	localparam logic [7:0] OUT_LEVEL0_A_ADDR     = 8'hC2;
	localparam logic [7:0] PORT_STRIDE           = 8'h20;

	localparam logic [7:0] LOOPBACK_CONTROL_RESET = 8'h00;
	localparam logic [7:0] OUT_CFG_RESET          = 8'h20;
	localparam logic [7:0] OUT_LEVEL1_RESET       = 8'h40;
	localparam logic [7:0] OUT_LEVEL0_RESET       = 8'h40;

	localparam logic [7:0] LOOPBACK_CONTROL_MASK = 8'h03;
	localparam logic [7:0] OUT_CFG_MASK          = 8'h37;
	localparam logic [7:0] OUT_LEVEL1_MASK       = 8'hFF;
	localparam logic [7:0] OUT_LEVEL0_MASK       = 8'h7F;

	localparam int CABLE_SIDE_LOOP_BIT  = 0;
	localparam int BOARD_SIDE_LOOP_BIT  = 1;
	localparam int EMPH_FIELD_LSB       = 0;
	localparam int EMPH_FIELD_W         = 3;
	localparam int DATA_RATE_BIT        = 4;
	localparam int OUT_ENABLE_BIT       = 5;
	localparam int EMPH_SOURCE_BIT      = 7;
	localparam int LEVEL_W              = 7;
	localparam int SERIAL_MODE_BIT      = 1;
	localparam int SYNC_STAGES          = 2;

	localparam logic [7:0] READ_UNMAPPED = 8'h00;

endpackage

// file: src/lbte_sync.sv
// Two-stage synchroniser for toggle pins driven by board logic.
// Assumes the inputs are quasi-static levels; no glitch filtering is done.
`timescale 1ns/1ps
module lbte_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// The first stage feeds only the second stage
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			meta_reg <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // lbte_sync

// file: verification/lbte_ctrl_assertions.sv
// Concurrent checks on the loopback and emphasis outputs of lbte_ctrl.
// Bound to every lbte_ctrl instance; sees only its ports.
`timescale 1ns/1ps
module lbte_ctrl_assertions
	import lbte_pkg::*;
#(
	parameter int N_LANES = 4
) (
	input wire logic                         clk,
	input wire logic                         reset,
	input wire logic [7:0]                   reg_addr,
	input wire logic                         reg_rd_en,
	input wire logic [7:0]                   reg_rdata,
	input wire logic [1:0]                   control_mode,
	input wire logic                         loopback_toggle_pin,
	input wire logic                         cable_loop_en,
	input wire logic                         board_loop_en,
	input wire logic                         port_a_through_en,
	input wire logic                         port_b_through_en,
	input wire logic                         port_a_out_from_b,
	input wire logic                         port_b_out_from_a,
	input wire logic [1:0][N_LANES-1:0][2:0] lane_emph_setting,
	input wire logic [1:0][N_LANES-1:0]      lane_rate_high
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_pin_no_cable: assert property (!control_mode[1] |=> !cable_loop_en)
		else $error("cable loop seen in pin mode");
	a_board_keeps_b: assert property (board_loop_en && !cable_loop_en |-> port_b_through_en)
		else $error("port B through path lost in board loop");
	a_full_drops_through: assert property (cable_loop_en && board_loop_en
		|-> !port_a_through_en && !port_b_through_en) else $error("through kept in full loop");
	a_b_from_a: assert property (port_b_out_from_a == cable_loop_en)
		else $error("port B output source wrong");
	a_a_from_b: assert property (port_a_out_from_b == board_loop_en)
		else $error("port A output source wrong");
	a_emph_joint: assert property (lane_emph_setting[0] == {N_LANES{lane_emph_setting[0][0]}}
		&& lane_emph_setting[1] == {N_LANES{lane_emph_setting[1][0]}}) else $error("lanes differ");
	a_rate_joint: assert property ((&lane_rate_high[0] || !(|lane_rate_high[0]))
		&& (&lane_rate_high[1] || !(|lane_rate_high[1]))) else $error("lane rates differ");
	a_loop_rsvd_zero: assert property (reg_rd_en && reg_addr == 8'h02
		|=> reg_rdata[7:2] == 6'h00) else $error("loopback reserved bits read nonzero");
	a_pin_board_follow: assert property (!$past(control_mode[1]) && !$past(reset)
		&& !$past(reset, 2) && !$past(reset, 3)
		|-> board_loop_en == $past(loopback_toggle_pin, 3))
		else $error("board loop does not follow the pin");
endmodule // lbte_ctrl_assertions

bind lbte_ctrl lbte_ctrl_assertions #(.N_LANES(N_LANES)) u_lbte_chk (
	.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
	.reg_rdata(reg_rdata), .control_mode(control_mode),
	.loopback_toggle_pin(loopback_toggle_pin), .cable_loop_en(cable_loop_en),
	.board_loop_en(board_loop_en), .port_a_through_en(port_a_through_en),
	.port_b_through_en(port_b_through_en), .port_a_out_from_b(port_a_out_from_b),
	.port_b_out_from_a(port_b_out_from_a), .lane_emph_setting(lane_emph_setting),
	.lane_rate_high(lane_rate_high));

// file: verification/lbte_host_model.sv
// Serial register host and board toggle-pin drivers facing lbte_ctrl.
// Drives on the falling edge of clk; each strobe lasts one cycle.
`timescale 1ns/1ps
module lbte_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr_en,
	output logic            reg_rd_en,
	output logic            loopback_toggle_pin,
	output logic      [1:0] emphasis_toggle_pins_a,
	output logic      [1:0] emphasis_toggle_pins_b
);
	initial
	begin
		reg_addr = 8'hFF;
		reg_wdata = 8'hFF;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		loopback_toggle_pin = 1'b0;
		emphasis_toggle_pins_a = 2'h0;
		emphasis_toggle_pins_b = 2'h0;
	end
	// Released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic pins(input logic lb, input logic [1:0] pa, input logic [1:0] pb);
		@(negedge clk);
		loopback_toggle_pin = lb;
		emphasis_toggle_pins_a = pa;
		emphasis_toggle_pins_b = pb;
	endtask
endmodule // lbte_host_model

// file: verification/tb_loopback_and_tx_emphasis_ctrl.sv
// Self-checking bench for lbte_ctrl against an integer model of its registers.
// Host model drives the register strobes and toggle pins.
`timescale 1ns/1ps
module tb_loopback_and_tx_emphasis_ctrl;
	import lbte_pkg::*;
	logic                 clk, reset, wr_en, rd_en, lb_pin, cab, brd, ta, tb, afb, bfa;
	logic [1:0]           mode, pe_a, pe_b;
	logic [7:0]           addr, wdata, rdata, rv;
	logic [1:0][3:0]      oe, rate, dlev;
	logic [1:0][3:0][2:0] emph;
	logic [1:0][3:0][6:0] lv1, lv0;
	int                   fail_count = 0, cmp_count = 0, m_lb = 0;
	int                   m_cfg[2] = '{32, 32}, m_l1[2] = '{64, 64}, m_l0[2] = '{64, 64};
	int                   m_wr[2] = '{0, 0}, lt[5] = '{8'h81, 8'h91, 8'h92, 8'hA2, 8'hA3};
	lbte_ctrl u_dut (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_rdata(rdata), .control_mode(mode),
		.loopback_toggle_pin(lb_pin), .emphasis_toggle_pins_a(pe_a),
		.emphasis_toggle_pins_b(pe_b), .cable_loop_en(cab), .board_loop_en(brd),
		.port_a_through_en(ta), .port_b_through_en(tb), .port_a_out_from_b(afb),
		.port_b_out_from_a(bfa), .lane_out_enable(oe), .lane_rate_high(rate),
		.lane_direct_level(dlev), .lane_emph_setting(emph), .lane_level1(lv1), .lane_level0(lv0));
	lbte_host_model u_host (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr_en(wr_en), .reg_rd_en(rd_en), .loopback_toggle_pin(lb_pin),
		.emphasis_toggle_pins_a(pe_a), .emphasis_toggle_pins_b(pe_b));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic w(input int a, input int d);
		u_host.wr(a[7:0], d[7:0]);
		if (a == 2) m_lb = d & 3;
		for (int p = 0; p < 2; p++)
		begin
			if (a == 8'hC0 + 32 * p) m_wr[p] = 1;
			if (a == 8'hC0 + 32 * p) m_cfg[p] = d & 8'h37;
			if (a == 8'hC1 + 32 * p) m_l1[p] = d & 8'hFF;
			if (a == 8'hC2 + 32 * p) m_l0[p] = d & 8'h7F;
		end
	endtask
	task automatic rchk(input int a, input int e);
		u_host.rd(a[7:0], rv);
		cmp(rv, e);
	endtask
	// Pin paths settle in three edges, so five falling edges cover every latency
	task automatic chk;
		int l;
		int e;
		repeat (5) @(negedge clk);
		l = mode[1] ? m_lb : 2 * lb_pin;
		cmp({bfa, cab, afb, brd}, {l[0], l[0], l[1], l[1]});
		cmp({ta, tb}, {2{l != 3}});
		for (int p = 0; p < 2; p++)
		begin
			e = m_wr[p] ? (m_cfg[p] & 7) : 2 * (p ? pe_b : pe_a);
			cmp(emph[p], {4{e[2:0]}});
			cmp({rate[p], oe[p]}, {{4{m_cfg[p][4]}}, {4{m_cfg[p][5]}}});
			cmp({dlev[p], lv1[p]}, {{4{m_l1[p][7]}}, {4{m_l1[p][6:0]}}});
			cmp(lv0[p], {4{m_l0[p][6:0]}});
		end
	endtask
	initial
	begin
		#200000;
		fail_count++;
		$display("unexpected %0t watchdog expired", $time);
		test_done;
	end
	initial
	begin
		reset = 1'b1;
		mode = 2'h0;
		void'($urandom(32'hCB55));
		repeat (5) @(negedge clk);
		reset = 1'b0;
		rchk(2, 0);
		rchk(8'hC0, 8'h20);
		rchk(8'hE1, 8'h40);
		rchk(8'h10, 0);
		chk;
		w(2, 3);
		for (int m = 0; m < 4; m++)
		begin
			mode = m[1:0];
			u_host.pins(m[0], $urandom, $urandom);
			chk;
		end
		for (int m = 2; m < 12; m++)
		begin
			mode = m[1:0] | 2'h2;
			w(2, m[1:0] | 8'hFC);
			u_host.pins($urandom, $urandom, $urandom);
			chk;
			rchk(2, m & 3);
		end
		mode = 2'h0;
		for (int k = 0; k < 4; k++)
		begin
			u_host.pins(k[0], k, 3 - k);
			chk;
		end
		for (int k = 0; k < 8; k++)
		begin
			w(8'hC0 + 32 * k[0], $urandom);
			u_host.pins(1'b0, k, ~k);
			chk;
			rchk(8'hC0 + 32 * k[0], m_cfg[k[0]]);
		end
		// Host keeps to supported output level pairs only
		for (int k = 0; k < 10; k++)
		begin
			w(8'hC1 + 32 * k[0], lt[k / 2]);
			w(8'hC2 + 32 * k[0], 8'h11 * (k / 2));
			chk;
		end
		w(8'hE1, 8'h40);
		chk;
		// A second reset must drop the sticky override and the serial loopback bits
		reset = 1'b1;
		mode = 2'h2;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		m_lb = 0;
		m_wr = '{0, 0};
		m_cfg = '{32, 32};
		m_l1 = '{64, 64};
		m_l0 = '{64, 64};
		chk;
		rchk(2, 0);
		test_done;
	end
endmodule // tb_loopback_and_tx_emphasis_ctrl
